// ---- mlcdlw_pkg.sv ----
// shared constants and types for the memory lcd line writer
package mlcdlw_pkg;
  localparam int unsigned COLS           = 128;
  localparam int unsigned ROWS           = 128;
  localparam int unsigned BITS_PER_PIXEL = 3;
  localparam int unsigned LINE_BITS      = COLS * BITS_PER_PIXEL;
  localparam int unsigned ADDR_BITS      = 8;
  localparam int unsigned FRAME_BITS     = ADDR_BITS + LINE_BITS;
  localparam int unsigned ROW_W          = 7;
  localparam int unsigned COL_W          = 7;
  localparam int unsigned BITCNT_W       = 9;
  // serial bit counter value at which a frame is complete
  localparam logic [8:0]  FRAME_LAST     = 9'(FRAME_BITS - 1);
  localparam logic [8:0]  FRAME_DONE     = 9'(FRAME_BITS);
  // system clock and polarity watchdog timing
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned POL_TIMEOUT_MS = 1000;
  localparam int unsigned POL_TIMEOUT_CYC = (CLK_HZ / 1000) * POL_TIMEOUT_MS;
  localparam int unsigned WDOG_W         = 26;
  localparam logic [15:0] LINES_RESET    = 16'h0000;

  // one received line: row address plus packed pixels
  typedef struct packed {
    logic [ADDR_BITS-1:0] row;
    logic [LINE_BITS-1:0] pixels;
  } mlcdlw_line_t;

  // pixel read answer
  typedef struct packed {
    logic [BITS_PER_PIXEL-1:0] colour;
    logic [ROW_W-1:0]          row;
    logic [COL_W-1:0]          col;
  } mlcdlw_pixel_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_DONE  = 2'b10
  } mlcdlw_state_t;
endpackage

// ---- mlcdlw_line_rx.sv ----
// serial line receiver running on the panel serial clock
`timescale 1ns/1ps
`default_nettype none
module mlcdlw_line_rx (
  input  wire logic                 panel_serial_clock,
  input  wire logic                 resetn,
  input  wire logic                 panel_chip_select,
  input  wire logic                 panel_serial_in,
  output mlcdlw_pkg::mlcdlw_line_t  line_word,
  output logic                      line_toggle
);
  import mlcdlw_pkg::*;

  logic [FRAME_BITS-1:0] shift;
  logic [FRAME_BITS-1:0] next_shift;
  logic [BITCNT_W-1:0]   bit_count;
  logic [BITCNT_W-1:0]   next_bit_count;
  logic                  next_line_toggle;
  mlcdlw_line_t          next_line_word;

  // shift msb first; bits past one frame are ignored until select drops
  always_comb begin
    next_shift       = {shift[FRAME_BITS-2:0], panel_serial_in};
    next_bit_count   = bit_count;
    next_line_toggle = line_toggle;
    next_line_word   = line_word;
    if (bit_count != FRAME_DONE) begin
      next_bit_count = bit_count + 9'h001;
    end
    if (bit_count == FRAME_LAST) begin
      next_line_word   = mlcdlw_line_t'(next_shift);
      next_line_toggle = ~line_toggle;
    end
  end

  // counter is cleared by select low, as the clock stops between frames
  always_ff @(posedge panel_serial_clock or negedge panel_chip_select) begin
    if (!panel_chip_select) begin
      bit_count <= 9'h000;
      shift     <= '0;
    end else begin
      bit_count <= next_bit_count;
      shift     <= next_shift;
    end
  end

  // captured line stays still until the next frame ends, so the
  // system domain may read it after the toggle has crossed
  always_ff @(posedge panel_serial_clock or negedge resetn) begin
    if (!resetn) begin
      line_word   <= '0;
      line_toggle <= 1'b0;
    end else begin
      line_word   <= next_line_word;
      line_toggle <= next_line_toggle;
    end
  end
endmodule
`default_nettype wire

// ---- mlcdlw_panel.sv ----
// memory lcd panel logic: line store, pixel readout, owner and polarity
// Function
// - grid of 128 columns by 128 rows
// - three colour bits per pixel, eight colours
// - written lines persist with no refresh
// - owner select low board, high user
// - bits taken only while select high
`timescale 1ns/1ps
`default_nettype none
module mlcdlw_panel #(
  parameter int unsigned POL_TIMEOUT = mlcdlw_pkg::POL_TIMEOUT_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  panel_serial_clock,
  input  wire logic                  panel_chip_select,
  input  wire logic                  panel_serial_in,
  input  wire logic                  panel_owner_select,
  input  wire logic                  polarity_inversion_pulse,
  input  wire logic                  pixel_req,
  input  wire logic [6:0]            pixel_row,
  input  wire logic [6:0]            pixel_col,
  output logic                       pixel_valid,
  output mlcdlw_pkg::mlcdlw_pixel_t  pixel_out,
  output logic                       line_written,
  output logic [6:0]                 last_row,
  output logic [15:0]                lines_total,
  output logic                       user_owns_panel,
  output logic                       com_polarity,
  output logic                       polarity_stale,
  output logic                       owner_swap_error
);
  import mlcdlw_pkg::*;

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // link-domain receiver
  mlcdlw_line_t rx_word;
  logic         rx_toggle;
  mlcdlw_line_rx u_rx (
    .panel_serial_clock (panel_serial_clock),
    .resetn             (rst_n),
    .panel_chip_select  (panel_chip_select),
    .panel_serial_in    (panel_serial_in),
    .line_word          (rx_word),
    .line_toggle        (rx_toggle)
  );

  // pin and cross-domain synchronisers; stage one feeds only stage two
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       tog_seen;
  logic [3:0] next_sync_b;
  assign next_sync_b = sync_a;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {rx_toggle, panel_chip_select, panel_owner_select,
                 polarity_inversion_pulse};
      sync_b <= next_sync_b;
    end
  end
  logic tog_s;
  logic cs_s;
  logic own_s;
  logic pol_s;
  assign tog_s = sync_b[3];
  assign cs_s  = sync_b[2];
  assign own_s = sync_b[1];
  assign pol_s = sync_b[0];

  // line store; not reset so an image outlives any stop of traffic
  logic [LINE_BITS-1:0] line_mem [ROWS];

  // write sequencer
  mlcdlw_state_t state;
  mlcdlw_state_t next_state;
  logic          next_tog_seen;
  logic          mem_we;
  logic [6:0]    next_last_row;
  logic [15:0]   next_lines_total;
  logic          next_line_written;
  always_comb begin
    next_state        = state;
    next_tog_seen     = tog_seen;
    mem_we            = 1'b0;
    next_last_row     = last_row;
    next_lines_total  = lines_total;
    next_line_written = 1'b0;
    case (state)
      ST_IDLE: begin
        if (tog_s != tog_seen) begin
          next_tog_seen = tog_s;
          // lines from a party that does not own the panel are dropped
          if (own_s) begin
            next_state = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        mem_we            = 1'b1;
        next_last_row     = rx_word.row[ROW_W-1:0];
        next_lines_total  = lines_total + 16'h0001;
        next_state        = ST_DONE;
      end
      ST_DONE: begin
        next_line_written = 1'b1;
        next_state        = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      tog_seen     <= 1'b0;
      last_row     <= 7'h00;
      lines_total  <= LINES_RESET;
      line_written <= 1'b0;
    end else begin
      state        <= next_state;
      tog_seen     <= next_tog_seen;
      last_row     <= next_last_row;
      lines_total  <= next_lines_total;
      line_written <= next_line_written;
    end
  end

  // only rows 0..127 exist; the address msb is ignored
  always_ff @(posedge clk) begin
    if (mem_we) begin
      line_mem[rx_word.row[ROW_W-1:0]] <= rx_word.pixels;
    end
  end

  // pixel readout, one cycle after the request
  mlcdlw_pixel_t next_pixel_out;
  logic          next_pixel_valid;
  logic [8:0]    bit_base;
  always_comb begin
    bit_base         = 9'(pixel_col) * 9'(BITS_PER_PIXEL);
    next_pixel_valid = pixel_req;
    next_pixel_out   = pixel_out;
    if (pixel_req) begin
      next_pixel_out.row    = pixel_row;
      next_pixel_out.col    = pixel_col;
      next_pixel_out.colour =
        line_mem[pixel_row][bit_base +: BITS_PER_PIXEL];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_valid <= 1'b0;
      pixel_out   <= '0;
    end else begin
      pixel_valid <= next_pixel_valid;
      pixel_out   <= next_pixel_out;
    end
  end

  // owner, polarity and watchdog state
  logic             pol_prev;
  logic             own_prev;
  logic [WDOG_W-1:0] wdog;
  logic [WDOG_W-1:0] next_wdog;
  logic             next_com_polarity;
  logic             next_polarity_stale;
  logic             next_owner_swap_error;
  logic             pol_rise;
  // own_prev keeps its reset value until the pin has crossed, so a
  // difference seen before then is not a real handover
  logic [2:0]        armed;
  logic [2:0]        next_armed;
  always_comb begin
    pol_rise              = pol_s & ~pol_prev;
    next_com_polarity     = com_polarity;
    next_polarity_stale   = polarity_stale;
    next_owner_swap_error = owner_swap_error;
    next_wdog             = wdog;
    next_armed            = {armed[1:0], 1'b1};
    // each pulse flips the panel's common polarity
    if (pol_rise) begin
      next_com_polarity   = ~com_polarity;
      next_wdog           = '0;
      next_polarity_stale = 1'b0;
    end else if (wdog == WDOG_W'(POL_TIMEOUT - 1)) begin
      // a held polarity builds charge; flag it, count is a limit only
      next_polarity_stale = 1'b1;
    end else begin
      next_wdog = wdog + 1'b1;
    end
    // handover in the middle of a frame leaves a partial line
    if ((own_s != own_prev) && cs_s && armed[2]) begin
      next_owner_swap_error = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_prev         <= 1'b0;
      own_prev         <= 1'b0;
      wdog             <= '0;
      com_polarity     <= 1'b0;
      polarity_stale   <= 1'b0;
      owner_swap_error <= 1'b0;
      user_owns_panel  <= 1'b0;
      armed            <= 3'h0;
    end else begin
      pol_prev         <= pol_s;
      own_prev         <= own_s;
      wdog             <= next_wdog;
      com_polarity     <= next_com_polarity;
      polarity_stale   <= next_polarity_stale;
      owner_swap_error <= next_owner_swap_error;
      user_owns_panel  <= own_s;
      armed            <= next_armed;
    end
  end
endmodule
`default_nettype wire

// ---- mlcdlw_asserts.sv ----
// concurrent checks on the panel logic ports
`timescale 1ns/1ps
`default_nettype none
module mlcdlw_asserts (
  input wire logic                      clk,
  input wire logic                      resetn,
  input wire logic                      pixel_req,
  input wire logic [6:0]                pixel_row,
  input wire logic [6:0]                pixel_col,
  input wire logic                      pixel_valid,
  input wire mlcdlw_pkg::mlcdlw_pixel_t pixel_out,
  input wire logic                      line_written,
  input wire logic [15:0]               lines_total,
  input wire logic                      user_owns_panel,
  input wire logic                      com_polarity,
  input wire logic                      owner_swap_error
);
  import mlcdlw_pkg::*;
  // one domain, so clock and reset are shared by all checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  pix_answer_a: assert property (pixel_req |=> pixel_valid)
    else $error("pixel answer missing");
  pix_place_a: assert property (pixel_req |=>
    pixel_out.row == $past(pixel_row) && pixel_out.col == $past(pixel_col))
    else $error("pixel answer at wrong place");
  pix_cause_a: assert property (pixel_valid |-> $past(pixel_req))
    else $error("pixel answer without request");
  lines_step_a: assert property ($changed(lines_total) |->
    lines_total == $past(lines_total) + 16'h0001)
    else $error("line count jumped");
  step_pulse_a: assert property (
    $changed(lines_total) |-> ##[0:1] line_written)
    else $error("line count moved without a stored line");
  line_pulse_a: assert property (line_written |=> !line_written)
    else $error("line pulse too long");
  owner_gate_a: assert property (line_written |-> user_owns_panel)
    else $error("line stored while board owns panel");
  swap_sticky_a: assert property (
    owner_swap_error |=> owner_swap_error)
    else $error("handover flag dropped without reset");
  // main scenarios reached
  cover property (line_written);
  cover property (pixel_req ##1 pixel_req);
  cover property ($changed(com_polarity));
  cover property ($rose(owner_swap_error));
endmodule
bind mlcdlw_panel mlcdlw_asserts i_mlcdlw_asserts (.clk(clk), .resetn(resetn),
  .pixel_req(pixel_req), .pixel_row(pixel_row), .pixel_col(pixel_col),
  .pixel_valid(pixel_valid), .pixel_out(pixel_out),
  .line_written(line_written), .lines_total(lines_total),
  .user_owns_panel(user_owns_panel), .com_polarity(com_polarity),
  .owner_swap_error(owner_swap_error));
`default_nettype wire

// ---- mlcdlw_host.sv ----
// host side model: shifts lines into the panel and pulses polarity
`timescale 1ns/1ps
`default_nettype none
module mlcdlw_host #(
  parameter int unsigned POL_HALF_NS = 600
) (
  output logic panel_serial_clock,
  output logic panel_chip_select,
  output logic panel_serial_in,
  output logic polarity_inversion_pulse
);
  logic pol_run = 1'b1;
  initial begin
    panel_serial_clock = 1'b0;
    panel_chip_select = 1'b0;
    panel_serial_in = 1'b0;
    polarity_inversion_pulse = 1'b0;
  end
  // free-running pulses, independent of line traffic
  always begin
    #(POL_HALF_NS);
    if (pol_run) begin
      polarity_inversion_pulse = ~polarity_inversion_pulse;
    end
  end
  // one clean rising edge on the polarity pin
  task automatic pulse;
    polarity_inversion_pulse = 1'b0;
    #100 polarity_inversion_pulse = 1'b1;
    #100 polarity_inversion_pulse = 1'b0;
  endtask
  // top n bits of a frame, msb first; clock stands low outside frames
  task automatic send(input logic [391:0] f, input int n);
    panel_chip_select = 1'b1;
    for (int i = 391; i > 391 - n; i--) begin
      panel_serial_in = f[i];
      // bench link runs at 15 ns, far above a panel's limit
      // to stress the crossing; the design does not depend on the rate
      #7.5 panel_serial_clock = 1'b1;
      #7.5 panel_serial_clock = 1'b0;
    end
    #15 panel_chip_select = 1'b0;
    panel_serial_in = ~panel_serial_in; // released line must not keep its bit
    #30;
  endtask
endmodule
`default_nettype wire

// ---- memory_lcd_line_writer_test.sv ----
// self-checking bench for the memory lcd panel logic
`timescale 1ns/1ps
`default_nettype none
module memory_lcd_line_writer_test;
  import mlcdlw_pkg::*;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  logic          panel_owner_select = 1'b1; // driven only here
  logic          pixel_req = 1'b0;
  logic [6:0]    pixel_row = 7'h00;
  logic [6:0]    pixel_col = 7'h00;
  logic          sclk, cs, si, pol, pixel_valid, line_written;
  logic          user_owns_panel, com_polarity, polarity_stale, swap_err;
  logic [6:0]    last_row;
  logic [15:0]   lines_total;
  mlcdlw_pixel_t pixel_out;
  int            err_total = 0;
  int            checks = 0;
  // short watchdog keeps the stale test brief
  mlcdlw_panel #(.POL_TIMEOUT(50)) i_mlcdlw_panel (.clk(clk),
    .resetn(resetn), .panel_serial_clock(sclk), .panel_chip_select(cs),
    .panel_serial_in(si), .panel_owner_select(panel_owner_select),
    .polarity_inversion_pulse(pol), .pixel_req(pixel_req),
    .pixel_row(pixel_row), .pixel_col(pixel_col), .pixel_valid(pixel_valid),
    .pixel_out(pixel_out), .line_written(line_written), .last_row(last_row),
    .lines_total(lines_total), .user_owns_panel(user_owns_panel),
    .com_polarity(com_polarity), .polarity_stale(polarity_stale),
    .owner_swap_error(swap_err));
  mlcdlw_host i_mlcdlw_host (.panel_serial_clock(sclk),
    .panel_chip_select(cs), .panel_serial_in(si),
    .polarity_inversion_pulse(pol));
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // row byte then pixels, column c holds colour (c + k) mod 8
  function automatic logic [391:0] frame(input logic [6:0] r, input int k);
    logic [383:0] p;
    for (int c = 0; c < 128; c++) p[3*c +: 3] = 3'((c + k) % 8);
    return {1'b0, r, p};
  endfunction
  // bounded watch for the stored-line pulse
  task automatic wait_line(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #2;
      if (line_written === 1'b1) seen = 1'b1;
    end
    chk(seen, exp);
    if (exp && !seen) stop_test();
  endtask
  task automatic rd_row(input logic [6:0] r, input int k);
    for (int c = 0; c < 128; c++) begin
      @(posedge clk);
      #2;
      pixel_req = 1'b1;
      pixel_row = r;
      pixel_col = 7'(c);
      @(posedge clk);
      #2;
      pixel_req = 1'b0;
      chk({pixel_valid, pixel_out},
          {1'b1, 3'((c + k) % 8), r, 7'(c)});
    end
  endtask
  // lines at both row bounds, read back after a later write
  task automatic t_lines;
    i_mlcdlw_host.send(frame(7'h00, 0), 392);
    wait_line(1'b1);
    chk({user_owns_panel, last_row}, {1'b1, 7'h00});
    i_mlcdlw_host.send(frame(7'h7F, 3), 392);
    wait_line(1'b1);
    chk({last_row, lines_total}, {7'h7F, 16'h0002});
    rd_row(7'h7F, 3);
    rd_row(7'h00, 0);
    $display("test lines done");
  endtask
  // short frame and board-owned frame are both dropped
  task automatic t_refuse;
    i_mlcdlw_host.send(frame(7'h05, 1), 200);
    wait_line(1'b0);
    panel_owner_select = 1'b0; // select low: safe handover
    repeat (4) @(posedge clk);
    #2;
    chk(user_owns_panel, 32'h0);
    i_mlcdlw_host.send(frame(7'h05, 1), 392);
    wait_line(1'b0);
    chk({lines_total, swap_err}, {16'h0002, 1'b0});
    panel_owner_select = 1'b1;
    $display("test refuse done");
  endtask
  // watchdog trips when pulses stop, a pulse flips polarity
  task automatic t_polarity;
    logic p0;
    chk(polarity_stale, 32'h0);
    i_mlcdlw_host.pol_run = 1'b0;
    repeat (60) @(posedge clk);
    #2;
    chk(polarity_stale, 32'h1);
    p0 = com_polarity;
    i_mlcdlw_host.pulse();
    repeat (6) @(posedge clk);
    #2;
    chk({com_polarity, polarity_stale}, {~p0, 1'b0});
    i_mlcdlw_host.pol_run = 1'b1;
    $display("test polarity done");
  endtask
  // handover in mid-frame is flagged and the line dropped; reset clears
  task automatic t_swap;
    fork
      i_mlcdlw_host.send(frame(7'h09, 2), 392);
      begin
        repeat (20) @(posedge clk);
        #2 panel_owner_select = 1'b0;
      end
    join
    wait_line(1'b0);
    chk({swap_err, lines_total}, {1'b1, 16'h0002});
    panel_owner_select = 1'b1;
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    chk({swap_err, lines_total}, {1'b0, 16'h0000});
    $display("test swap done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (3) @(posedge clk);
    t_lines();
    t_refuse();
    t_polarity();
    t_swap();
    stop_test();
  end
endmodule
`default_nettype wire
